// ==== dmr_ctl.sv ====
// Controller side: AXI4-Lite registers that issue mode register sets
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
`include "dmr_params.svh"
module dmr_ctl
  import dmr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Command link
  dmr_link_if.ctl          link,
  // Bank and traffic state from the rest of the controller
  input  wire logic        banksIdle,
  input  wire logic        readReq,
  input  wire logic        writeReq,
  input  wire logic        levelMode
);
  dmr_ctl_e    st_r;
  dmr_mode_t   m2_r;
  dmr_mode_t   m3_r;
  logic        goSel_r;
  logic        pend_r;
  logic [4:0]  wait_r;
  logic        awHeld_r;
  logic        wHeld_r;
  logic        wStrb0_r;
  logic [11:0] awAddr_r;
  logic [31:0] wData_r;
  logic        cal_r;
  logic        modeSet_r;
  logic [2:0]  ba_r;
  logic [16:0] ad_r;
  logic        doWrite;

  localparam logic [4:0] WAIT_CYC = 5'(`DMR_MODE_SET_CYC + `DMR_MODE_UPD_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r  <= 32'h00000000;
      wStrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        // Strobe only stands with wvalid, so keep it with the data
        wStrb0_r <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Registers; reserved bits forced to zero before they reach the link
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      m2_r    <= `DMR_M2_RESET;
      m3_r    <= `DMR_M3_RESET;
      goSel_r <= 1'b0;
      pend_r  <= 1'b0;
    end
    else
    begin
      if (doWrite && wStrb0_r && awAddr_r == `DMR_OFF_CTRL && st_r == DMR_IDLE)
      begin
        pend_r  <= 1'b1;
        goSel_r <= wData_r[0];
      end
      else if (st_r == DMR_SEND)
        pend_r <= 1'b0;
      if (doWrite && awAddr_r == `DMR_OFF_M2)
        m2_r <= wData_r[16:0] & ~`DMR_M2_RSVD_MASK;
      if (doWrite && awAddr_r == `DMR_OFF_M3)
        m3_r <= wData_r[16:0] & ~`DMR_M3_RSVD_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: issue only with banks idle, then hold off both delays
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r      <= DMR_IDLE;
      wait_r    <= 5'h00;
      modeSet_r <= 1'b0;
      ba_r      <= 3'h0;
      ad_r      <= 17'h00000;
      cal_r     <= 1'b0;
    end
    else
    begin
      modeSet_r <= 1'b0;
      case (st_r)
        DMR_IDLE:
          if (pend_r && banksIdle)
            st_r <= DMR_SEND;
        DMR_SEND:
        begin
          modeSet_r <= 1'b1;
          ba_r      <= goSel_r ? `DMR_BA_MODE_THREE : `DMR_BA_MODE_TWO;
          // Never both refresh-rate bits at once; forced rate wins
          ad_r      <= goSel_r ? m3_r : (m2_r[`DMR_M2_FDR_BIT] ?
                       (m2_r & ~(17'h1 << `DMR_M2_ASR_BIT)) : m2_r);
          if (goSel_r)
            cal_r <= m3_r[`DMR_M3_CRO_BIT];
          wait_r <= WAIT_CYC;
          st_r   <= DMR_WAIT;
        end
        DMR_WAIT:
          if (wait_r == 5'h00)
            st_r <= DMR_IDLE;
          else
            wait_r <= wait_r - 5'h01;
        default:
          st_r <= DMR_IDLE;
      endcase
    end
  end

  // Traffic blocked during delays; only reads while readout is on
  assign link.modeSet    = modeSet_r;
  assign link.bankAddr   = ba_r;
  assign link.addr       = ad_r;
  assign link.allIdle    = banksIdle;
  assign link.readCmd    = readReq && st_r == DMR_IDLE && !pend_r;
  assign link.writeBurst = writeReq && st_r == DMR_IDLE && !pend_r && !cal_r;
  assign link.writeLevel = levelMode;

  ////////////////////////////////////////////////////////////////////////
  // Read channel; status shows sequencer state. Extended-range refresh
  // doubling is the refresh scheduler's job, set via mode two
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `DMR_OFF_CTRL: s_axi_rdata <= {31'h0, goSel_r};
        `DMR_OFF_M2:   s_axi_rdata <= {15'h0, m2_r};
        `DMR_OFF_M3:   s_axi_rdata <= {15'h0, m3_r};
        `DMR_OFF_STAT: s_axi_rdata <= {27'h0, link.rdValid, cal_r, st_r};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule // dmr_ctl
`default_nettype wire

// ==== dmr_params.svh ====
// Constants for the DRAM mode register two/three block
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH
// Mode register select codes on the bank address
`define DMR_BA_MODE_TWO     3'h2
`define DMR_BA_MODE_THREE   3'h3
// Mode register two fields
`define DMR_M2_CWD_LSB      3
`define DMR_M2_CWD_MSB      5
`define DMR_M2_ASR_BIT      6
`define DMR_M2_FDR_BIT      7
`define DMR_M2_WTT_LSB      9
`define DMR_M2_WTT_MSB      10
`define DMR_M2_RSVD_MASK    17'h13907
// Mode register three fields
`define DMR_M3_SEL_LSB      0
`define DMR_M3_SEL_MSB      1
`define DMR_M3_CRO_BIT      2
`define DMR_M3_RSVD_MASK    17'h13FF8
// Reset values
`define DMR_M2_RESET        17'h00000
`define DMR_M3_RESET        17'h00000
// Predefined calibration burst, bit 0 first
`define DMR_CAL_PATTERN     8'hAA
// Mode set and mode update delays in clock cycles
`define DMR_MODE_SET_CYC    4
`define DMR_MODE_UPD_CYC    12
// Offsets of the controller's own registers
`define DMR_OFF_CTRL        12'h000
`define DMR_OFF_M2          12'h004
`define DMR_OFF_M3          12'h008
`define DMR_OFF_STAT        12'h00C
`endif

// ==== dmr_pkg.sv ====
// Types shared by both ends of the mode register link
`default_nettype none
package dmr_pkg;
  typedef logic [16:0] dmr_mode_t;
  typedef logic [2:0]  dmr_bank_t;
  typedef enum logic [2:0]
  {
    DMR_IDLE = 3'h1,
    DMR_SEND = 3'h2,
    DMR_WAIT = 3'h4
  } dmr_ctl_e;
endpackage
`default_nettype wire

// ==== dmr_link_if.sv ====
// Command link between memory controller and DRAM mode logic
`default_nettype none
interface dmr_link_if;
  logic        modeSet;
  logic [2:0]  bankAddr;
  logic [16:0] addr;
  logic        allIdle;
  logic        readCmd;
  logic        writeBurst;
  logic        writeLevel;
  logic        rdValid;
  logic [7:0]  rdData;
  modport dev
  (
    input  modeSet, bankAddr, addr, allIdle, readCmd, writeBurst, writeLevel,
    output rdValid, rdData
  );
  modport ctl
  (
    output modeSet, bankAddr, addr, allIdle, readCmd, writeBurst, writeLevel,
    input  rdValid, rdData
  );
endinterface
`default_nettype wire

// ==== dmr_dev.sv ====
// DRAM side: holds mode registers two and three and applies their fields
`default_nettype none
`include "dmr_params.svh"
module dmr_dev
  import dmr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Command link
  dmr_link_if.dev         link,
  // Temperature and latency context
  input  wire logic [3:0] additive_latency,
  input  wire logic       hotCase,
  input  wire logic       warmCase,
  // Applied settings
  output logic [3:0]      write_cas_delay,
  output logic [4:0]      total_write_latency,
  output logic            doubleRefresh,
  output logic [1:0]      write_termination,
  output logic            writeTermActive,
  output logic            calReadout
);
  dmr_mode_t  modeTwo_r;
  dmr_mode_t  modeThree_r;
  logic       mode2Hit;
  logic       mode3Hit;
  logic       cal0;
  logic [7:0] rdData_r;
  logic       rdSelCal;

  assign mode2Hit = link.modeSet && (link.bankAddr == `DMR_BA_MODE_TWO);
  assign mode3Hit = link.modeSet && (link.bankAddr == `DMR_BA_MODE_THREE);

  ////////////////////////////////////////////////////////////////////////
  // Only the mode registers change here; array data lives elsewhere
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      modeTwo_r <= `DMR_M2_RESET;
    else if (mode2Hit)
      modeTwo_r <= link.addr;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      modeThree_r <= `DMR_M3_RESET;
    else if (mode3Hit)
      modeThree_r <= link.addr;
  end

  ////////////////////////////////////////////////////////////////////////
  // Encoded field is offset by five clocks per the usual table
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      write_cas_delay     <= 4'h5;
      total_write_latency <= 5'h05;
    end
    else
    begin
      write_cas_delay <= {1'b0, modeTwo_r[`DMR_M2_CWD_MSB:`DMR_M2_CWD_LSB]} + 4'h5;
      total_write_latency <= {1'b0, write_cas_delay} + {1'b0, additive_latency};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Warm threshold lets auto mode switch early, which is always safe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      doubleRefresh <= 1'b0;
    else
      doubleRefresh <= modeTwo_r[`DMR_M2_FDR_BIT] ||
                       (modeTwo_r[`DMR_M2_ASR_BIT] && (hotCase || warmCase));
  end

  ////////////////////////////////////////////////////////////////////////
  // Write termination runs without any nominal setting in play
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      write_termination <= 2'h0;
      writeTermActive   <= 1'b0;
    end
    else
    begin
      write_termination <= modeTwo_r[`DMR_M2_WTT_MSB:`DMR_M2_WTT_LSB];
      writeTermActive   <= (modeTwo_r[`DMR_M2_WTT_MSB:`DMR_M2_WTT_LSB] != 2'h0) &&
                           link.writeBurst && !link.writeLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Selector ignored when readout is off; nonzero selector undefined
  assign rdSelCal = modeThree_r[`DMR_M3_CRO_BIT] &&
                    (modeThree_r[`DMR_M3_SEL_MSB:`DMR_M3_SEL_LSB] == 2'h0);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cal0     <= 1'b0;
      rdData_r <= 8'h00;
    end
    else
    begin
      cal0     <= link.readCmd && modeThree_r[`DMR_M3_CRO_BIT];
      // Pattern only for selector 00; other selectors read as zero
      rdData_r <= (link.readCmd && rdSelCal) ? `DMR_CAL_PATTERN : 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      calReadout <= 1'b0;
    else
      calReadout <= modeThree_r[`DMR_M3_CRO_BIT];
  end

  assign link.rdValid = cal0;
  assign link.rdData  = rdData_r;
endmodule // dmr_dev
`default_nettype wire

// ==== dmr_link_asserts.sv ====
// Concurrent checks on the mode register command link
`default_nettype none
`include "dmr_params.svh"
module dmr_link_asserts
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Link signals
  input wire logic        modeSet,
  input wire logic [2:0]  bankAddr,
  input wire logic [16:0] addr,
  input wire logic        allIdle,
  input wire logic        readCmd,
  input wire logic        writeBurst,
  input wire logic        rdValid,
  input wire logic [7:0]  rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       calOn_r;
  logic [1:0] calSel_r;
  logic       setTwo;
  logic       setThree;
  assign setTwo = modeSet && bankAddr == `DMR_BA_MODE_TWO;
  assign setThree = modeSet && bankAddr == `DMR_BA_MODE_THREE;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Mirror of the readout state so read checks know what to expect
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      calOn_r  <= 1'b0;
      calSel_r <= 2'h0;
    end
    else if (setThree)
    begin
      calOn_r  <= addr[`DMR_M3_CRO_BIT];
      calSel_r <= addr[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_mode_bank_code: assert property (modeSet |-> setTwo || setThree)
    else $error("mode set with a bank code other than two or three");
  a_two_rsvd_zero: assert property (setTwo |-> (addr & `DMR_M2_RSVD_MASK) == 17'h0)
    else $error("mode two load with reserved bits set");
  a_three_rsvd_zero: assert property (setThree |-> (addr & `DMR_M3_RSVD_MASK) == 17'h0)
    else $error("mode three load with reserved bits set");
  a_refresh_excl: assert property (setTwo |-> !(addr[6] && addr[7]))
    else $error("both refresh options loaded together");
  a_mode_when_idle: assert property (modeSet |-> allIdle && !writeBurst)
    else $error("mode set while banks busy or burst active");
  a_mode_spacing: assert property (modeSet |=> !modeSet [*8])
    else $error("mode sets too close together");
  a_read_redirect: assert property (readCmd && calOn_r |=> rdValid)
    else $error("read during readout gave no calibration data");
  a_normal_read: assert property (readCmd && !calOn_r |=> !rdValid)
    else $error("calibration data outside readout mode");
  a_cal_pattern: assert property (rdValid && calSel_r == 2'h0 |-> rdData == `DMR_CAL_PATTERN)
    else $error("wrong calibration pattern");
  a_cal_no_write: assert property (calOn_r |-> !writeBurst)
    else $error("write burst during readout");
  c_load_two: cover property (setTwo);
  c_load_three: cover property (setThree && addr[2]);
  c_cal_read: cover property (rdValid && calOn_r);
endmodule // dmr_link_asserts
`default_nettype wire

// ==== dram_mode_regs_two_three_tb.sv ====
// Testbench for the mode register controller and device pair
`default_nettype none
`include "dmr_params.svh"
module dram_mode_regs_two_three_tb
  import dmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rstn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, addLat = 4'h2, wcd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, dblRef, wTermOn, calOn;
  logic [1:0] s_axi_bresp, s_axi_rresp, wTerm, rr;
  logic banksIdle = 1'b1, readReq = 1'b0, writeReq = 1'b0, levelMode = 1'b0;
  logic hotCase = 1'b0, warmCase = 1'b0, v;
  logic [4:0] twl;
  logic [7:0] d;
  logic [31:0] s;
  int fail_count = 0, num_checks = 0;
  logic [33:0] asrTab [5] = '{{32'h40, 2'b00}, {32'h40, 2'b10}, {32'h40, 2'b01},
                              {32'hC0, 2'b00}, {32'h00, 2'b10}};
  logic asrExp [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  dmr_link_if link_if();
  dmr_ctl dmr_ctl_inst(.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link(link_if), .banksIdle, .readReq, .writeReq, .levelMode);
  dmr_dev dmr_dev_inst(.sys_clk, .rstn, .link(link_if), .additive_latency(addLat), .hotCase,
    .warmCase, .write_cas_delay(wcd), .total_write_latency(twl), .doubleRefresh(dblRef),
    .write_termination(wTerm), .writeTermActive(wTermOn), .calReadout(calOn));
  dmr_link_asserts dmr_link_asserts_inst(.sys_clk, .rstn, .modeSet(link_if.modeSet),
    .bankAddr(link_if.bankAddr), .addr(link_if.addr), .allIdle(link_if.allIdle),
    .readCmd(link_if.readCmd), .writeBurst(link_if.writeBurst), .rdValid(link_if.rdValid),
    .rdData(link_if.rdData));
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus waits are open ended; only the watchdog ends a hang
  task automatic axiWr(input logic [11:0] a, input logic [31:0] dw);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'h0);
  endtask
  task automatic axiRd(input logic [11:0] a, output logic [31:0] dr, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    dr = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Start a mode set, then poll status until the delays have run out
  task automatic issue(input logic [31:0] sel);
    axiWr(`DMR_OFF_CTRL, sel);
    do axiRd(`DMR_OFF_STAT, s, rr);
    while (s[2:0] !== DMR_IDLE);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic readPulse();
    int n;
    n = 0;
    v = 1'b0;
    d = 8'h00;
    @(posedge sys_clk) readReq <= 1'b1;
    @(posedge sys_clk) readReq <= 1'b0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (link_if.rdValid)
      begin
        v = 1'b1;
        d = link_if.rdData;
      end
    end while (!v && n < 4);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    // Total latency needs one edge after reset to pick up the additive part
    repeat (3) @(posedge sys_clk);
    chk(wcd, 5);
    chk(twl, 5 + addLat);
    axiRd(12'h010, s, rr);
    chk(rr, 2);
    chk(s, 0);
    // Reserved bits set on purpose; the controller must strip them
    banksIdle <= 1'b0;
    axiWr(`DMR_OFF_M2, 32'h0001_0499);
    axiRd(`DMR_OFF_M2, s, rr);
    chk(s, 32'h0000_0498);
    axiWr(`DMR_OFF_CTRL, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk(wcd, 5);
    banksIdle <= 1'b1;
    issue(32'h0);
    chk(wcd, 8);
    chk(twl, 8 + addLat);
    chk(dblRef, 1);
    chk(wTerm, 2);
    writeReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(wTermOn, 1);
    levelMode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(wTermOn, 0);
    levelMode <= 1'b0;
    writeReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(wTermOn, 0);
    for (int i = 0; i < 5; i++)
    begin
      axiWr(`DMR_OFF_M2, asrTab[i][33:2]);
      issue(32'h0);
      hotCase <= asrTab[i][1];
      warmCase <= asrTab[i][0];
      repeat (3) @(posedge sys_clk);
      chk(dblRef, asrExp[i]);
      chk(wTerm, 0);
    end
    axiWr(`DMR_OFF_M3, 32'h0001_0004);
    axiRd(`DMR_OFF_M3, s, rr);
    chk(s, 32'h0000_0004);
    issue(32'h1);
    chk(calOn, 1);
    repeat (2)
    begin
      readPulse();
      chk({v, d}, {1'b1, `DMR_CAL_PATTERN});
    end
    // A write request during readout must not reach the link
    writeReq <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(link_if.writeBurst, 0);
    writeReq <= 1'b0;
    axiWr(`DMR_OFF_M3, 32'h5);
    issue(32'h1);
    readPulse();
    chk({v, d}, 9'h100);
    axiWr(`DMR_OFF_M3, 32'h3);
    issue(32'h1);
    chk(calOn, 0);
    readPulse();
    chk(v, 0);
    complete_run();
  end
endmodule // dram_mode_regs_two_three_tb
`default_nettype wire
